// File: rtl/frm_pkg.sv
// Purpose: constants, carriers and state layout of the fault-response and alert manager
// Assumes: 10 MHz system clock, command codes as seen by the bus protocol engine
// Notes: one channel per instance
package frm_pkg;
    // command codes
    localparam logic [7:0] CODE_CLEAR = 8'h03;
    localparam logic [7:0] CODE_MASK = 8'h1b;
    localparam logic [7:0] CODE_OC = 8'h47;
    localparam logic [7:0] CODE_OT = 8'h50;
    localparam logic [7:0] CODE_TON = 8'h63;
    localparam logic [7:0] CODE_SBYTE = 8'h78;
    localparam logic [7:0] CODE_SWORD = 8'h79;
    localparam logic [7:0] CODE_SVOUT = 8'h7a;
    localparam logic [7:0] CODE_SIOUT = 8'h7b;
    localparam logic [7:0] CODE_STEMP = 8'h7d;
    localparam logic [7:0] CODE_SCOMM = 8'h7e;
    localparam logic [7:0] CODE_SMFR = 8'h80;
    localparam logic [7:0] CODE_CHCFG = 8'hd0;
    localparam logic [7:0] CODE_PROP = 8'hd2;
    localparam logic [7:0] CODE_FLI = 8'hd5;
    localparam logic [7:0] CODE_RETRY = 8'hdb;
    // reset values
    localparam logic [7:0] RST_TON = 8'h00;
    localparam logic [7:0] RST_OC = 8'h00;
    localparam logic [7:0] RST_OT = 8'hc0;
    localparam logic [7:0] RST_FLI = 8'hc0;
    localparam logic [7:0] RST_CHCFG = 8'h00;
    localparam logic [15:0] RST_PROP = 16'he0d7;
    localparam logic [15:0] RST_RETRY = 16'h000a;
    localparam logic [7:0] RST_MSK_IOUT = 8'h80;
    localparam logic [7:0] RST_MSK_MFR = 8'h01;
    localparam logic [15:0] PROP_WRITABLE = 16'he0d7;
    // action byte fields and codes
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [1:0] RESP_CONT = 2'h0;
    localparam logic [1:0] RESP_BAD = 2'h1;
    localparam logic [1:0] RESP_TEN = 2'h2;
    localparam logic [1:0] RESP_ELEVEN = 2'h3;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam logic [2:0] DELAY_ZERO = 3'h0;
    localparam logic [7:0] FLI_STOP = 8'hc0;
    localparam logic [7:0] FLI_CONT = 8'h00;
    // bit positions
    localparam int PROP_DISCH = 15;
    localparam int PROP_TON = 13;
    localparam int PROP_OT = 7;
    localparam int PROP_OC = 2;
    localparam int SV_TON = 2;
    localparam int SI_OC = 7;
    localparam int ST_OT = 7;
    localparam int SC_CMD = 7;
    localparam int SC_DATA = 6;
    localparam int SM_EXT = 0;
    localparam int CFG_NODISCH = 0;
    localparam int CFG_NOMFR = 1;
    localparam int SB_OFF = 6;
    localparam int SB_IOUT_OC = 4;
    localparam int SB_TEMP = 2;
    localparam int SB_COMM = 1;
    localparam int SB_NOTA = 0;
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_MFR = 12;
    // input synchroniser lanes
    localparam int SY_ON = 0;
    localparam int SY_TON = 1;
    localparam int SY_OC = 2;
    localparam int SY_OT = 3;
    localparam int SY_ABOVE = 4;
    localparam int SY_FLINE = 5;
    localparam int SYNC_W = 6;
    // fault line idles high; a low reset value would fake an external pull-down
    localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(1) << SY_FLINE;
    // timing: one tick per delay step
    localparam int TICK_US = 10;
    localparam int CLK_KHZ = 10000;
    localparam int TICK_CYCLES = TICK_US * CLK_KHZ / 1000;
    localparam int TICK_W = $clog2(TICK_CYCLES);

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_LATCHED, ST_RETRY} frm_chan_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] data;
    } frm_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } frm_rsp_t;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        frm_chan_t st;
        logic [7:0] tonAct;
        logic [7:0] ocAct;
        logic [7:0] otAct;
        logic [7:0] fliAct;
        logic [7:0] chanCfg;
        logic [15:0] propSel;
        logic [15:0] retryIvl;
        logic [7:0] sVout;
        logic [7:0] sIout;
        logic [7:0] sTemp;
        logic [7:0] sComm;
        logic [7:0] sMfr;
        logic extSeen;
        logic [7:0] mVout;
        logic [7:0] mIout;
        logic [7:0] mTemp;
        logic [7:0] mComm;
        logic [7:0] mMfr;
        logic [TICK_W-1:0] tickCnt;
        logic [2:0] ocCnt;
        logic [15:0] retryCnt;
        logic faultDrive;
        logic [1:0] drvHist;
        logic dischHold;
        logic outEn;
        logic limit;
        logic alert;
        frm_rsp_t rsp;
    } frm_state_t;

    localparam frm_state_t STATE_RST = '{sync1: SYNC_IDLE, sync2: SYNC_IDLE,
        st: ST_IDLE, tonAct: RST_TON, ocAct: RST_OC,
        otAct: RST_OT, fliAct: RST_FLI, chanCfg: RST_CHCFG, propSel: RST_PROP,
        retryIvl: RST_RETRY, mIout: RST_MSK_IOUT, mMfr: RST_MSK_MFR, default: '0};
endpackage

// File: rtl/frm_fault_alert.sv
// Purpose: fault responses, fault line sharing and alert generation for one channel
// Assumes: protocol engine delivers decoded commands; detectors and pins are asynchronous
// Notes: fault, alert pins are open drain, enables low while pulling low
`timescale 1ns/10ps
module frm_fault_alert (
    input wire logic clk_sys,
    input wire logic reset,
    input frm_pkg::frm_cmd_t cmd,
    output frm_pkg::frm_rsp_t rsp,
    input wire logic chanOnPin,
    input wire logic tonMaxDet,
    input wire logic overcurrentDet,
    input wire logic overtempDet,
    input wire logic aboveDecayThr,
    input wire logic faultLineIn,
    output logic faultLineOut,
    output logic faultLineOe_n,
    output logic alertOut,
    output logic alertOe_n,
    output logic outputEnable,
    output logic currentLimitActive
);
    import frm_pkg::*;

    frm_state_t s;
    frm_state_t n;
    logic [SYNC_W-1:0] syncIn;
    logic chanOn, tonDet, ocDet, otDet, above, extLow, running, tick;
    logic tonTrip, ocTrip, otTrip, otHold, extStop, latchAny, propHit, condNow;
    logic rejWr, badCmd;
    logic [7:0] statByte;
    logic [15:0] statWord;

    assign syncIn = {faultLineIn, aboveDecayThr, overtempDet, overcurrentDet, tonMaxDet, chanOnPin};

    always_comb begin
        n = s;
        n.sync1 = syncIn;
        n.sync2 = s.sync1;
        chanOn = s.sync2[SY_ON];
        tonDet = s.sync2[SY_TON];
        ocDet = s.sync2[SY_OC];
        otDet = s.sync2[SY_OT];
        above = s.sync2[SY_ABOVE];
        // own pull-down echoes back through the synchroniser for two cycles
        extLow = !s.sync2[SY_FLINE] && !s.faultDrive && (s.drvHist == 2'h0);
        running = (s.st == ST_RUN) && chanOn;
        tick = (s.tickCnt == TICK_W'(TICK_CYCLES - 1));
        n.tickCnt = tick ? '0 : s.tickCnt + 1'b1;
        n.drvHist = {s.drvHist[0], s.faultDrive};
        rejWr = 1'b0;
        badCmd = 1'b0;

        // overcurrent delay; first step may be short by up to one tick
        if (running && ocDet && s.ocAct[RESP_HI:RESP_LO] == RESP_TEN) begin
            if (tick && s.ocCnt != s.ocAct[DELAY_HI:DELAY_LO]) begin
                n.ocCnt = s.ocCnt + 1'b1;
            end
        end else begin
            n.ocCnt = '0;
        end

        tonTrip = running && tonDet && s.tonAct[RESP_HI:RESP_LO] == RESP_TEN;
        ocTrip = running && ocDet && (s.ocAct[RESP_HI:RESP_LO] == RESP_ELEVEN
            || (s.ocAct[RESP_HI:RESP_LO] == RESP_TEN
            && s.ocCnt == s.ocAct[DELAY_HI:DELAY_LO]));
        otTrip = running && otDet && s.otAct[RESP_HI:RESP_LO] == RESP_TEN;
        otHold = chanOn && otDet && s.otAct[RESP_HI:RESP_LO] == RESP_ELEVEN;
        extStop = chanOn && extLow && s.fliAct == FLI_STOP;
        latchAny = (tonTrip && s.tonAct[RETRY_HI:RETRY_LO] != RETRY_FOREVER)
            || (ocTrip && s.ocAct[RETRY_HI:RETRY_LO] != RETRY_FOREVER) || otTrip;
        propHit = (tonTrip && s.propSel[PROP_TON]) || (ocTrip && s.propSel[PROP_OC])
            || ((otTrip || otHold) && s.propSel[PROP_OT])
            || (chanOn && s.dischHold && s.propSel[PROP_DISCH]);
        condNow = tonDet || ocDet || otDet;

        case (s.st)
            ST_IDLE: begin
                if (chanOn) begin
                    n.st = ST_RUN;
                    n.dischHold = above && !s.chanCfg[CFG_NODISCH];
                end
            end
            ST_RUN: begin
                if (tonTrip || ocTrip || otTrip) begin
                    n.st = latchAny ? ST_LATCHED : ST_RETRY;
                    n.retryCnt = '0;
                end
            end
            ST_RETRY: begin
                if (tick) begin
                    if (s.retryCnt >= s.retryIvl) begin
                        n.retryCnt = '0;
                        if (!condNow) begin
                            n.st = ST_RUN;
                            n.faultDrive = 1'b0;
                        end
                    end else begin
                        n.retryCnt = s.retryCnt + 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
        if (!above) begin
            n.dischHold = 1'b0;
        end
        if (propHit) begin
            n.faultDrive = 1'b1;
        end
        if (!chanOn) begin
            n.st = ST_IDLE;
            n.faultDrive = 1'b0;
            n.dischHold = 1'b0;
        end
        n.outEn = running && !otHold && !extStop && !s.dischHold;
        n.limit = running && ocDet && (s.ocAct[RESP_HI:RESP_LO] == RESP_CONT
            || s.ocAct[RESP_HI:RESP_LO] == RESP_TEN);

        // summaries are derived, never stored
        statWord = '0;
        statWord[SW_VOUT] = |s.sVout;
        statWord[SW_IOUT] = |s.sIout;
        statWord[SW_MFR] = |s.sMfr || |s.sTemp || s.extSeen;
        statByte = '0;
        statByte[SB_OFF] = !s.outEn;
        statByte[SB_IOUT_OC] = s.sIout[SI_OC];
        statByte[SB_TEMP] = |s.sTemp;
        statByte[SB_COMM] = |s.sComm;
        statByte[SB_NOTA] = |statWord[15:12];
        statWord[7:0] = statByte;

        // writes; refused ones leave stored values alone
        if (cmd.wr) begin
            if (cmd.code == CODE_CLEAR) begin
                n.sVout = '0;
                n.sIout = '0;
                n.sTemp = '0;
                n.sComm = '0;
                n.sMfr = '0;
                n.extSeen = 1'b0;
            end else if (cmd.code == CODE_TON) begin
                if (cmd.data[RESP_LO]
                    || cmd.data[DELAY_HI:DELAY_LO] != DELAY_ZERO) begin
                    rejWr = 1'b1;
                end else begin
                    n.tonAct = cmd.data[7:0];
                end
            end else if (cmd.code == CODE_OC) begin
                if (cmd.data[RESP_HI:RESP_LO] == RESP_BAD) begin
                    rejWr = 1'b1;
                end else begin
                    n.ocAct = cmd.data[7:0];
                end
            end else if (cmd.code == CODE_OT) begin
                if (!cmd.data[RESP_HI]
                    || cmd.data[RETRY_HI:RETRY_LO] == RETRY_FOREVER) begin
                    rejWr = 1'b1;
                end else begin
                    n.otAct = cmd.data[7:0];
                end
            end else if (cmd.code == CODE_FLI) begin
                if (cmd.data[7:0] != FLI_STOP && cmd.data[7:0] != FLI_CONT) begin
                    rejWr = 1'b1;
                end else begin
                    n.fliAct = cmd.data[7:0];
                end
            end else if (cmd.code == CODE_PROP) begin
                n.propSel = cmd.data & PROP_WRITABLE;
            end else if (cmd.code == CODE_CHCFG) begin
                n.chanCfg = cmd.data[7:0];
            end else if (cmd.code == CODE_RETRY) begin
                n.retryIvl = cmd.data;
            end else if (cmd.code == CODE_SVOUT) begin
                n.sVout = s.sVout & ~cmd.data[7:0];
            end else if (cmd.code == CODE_SIOUT) begin
                n.sIout = s.sIout & ~cmd.data[7:0];
            end else if (cmd.code == CODE_STEMP) begin
                n.sTemp = s.sTemp & ~cmd.data[7:0];
            end else if (cmd.code == CODE_SCOMM) begin
                n.sComm = s.sComm & ~cmd.data[7:0];
            end else if (cmd.code == CODE_SMFR) begin
                n.sMfr = s.sMfr & ~cmd.data[7:0];
                n.extSeen = s.extSeen && !cmd.data[SM_EXT];
            end else if (cmd.code == CODE_SBYTE || cmd.code == CODE_SWORD) begin
                n.sComm = s.sComm; // derived summaries hold nothing to clear
            end else if (cmd.code == CODE_MASK) begin
                if (cmd.data[15:8] == CODE_SVOUT) begin
                    n.mVout = cmd.data[7:0];
                end else if (cmd.data[15:8] == CODE_SIOUT) begin
                    n.mIout = cmd.data[7:0];
                end else if (cmd.data[15:8] == CODE_STEMP) begin
                    n.mTemp = cmd.data[7:0];
                end else if (cmd.data[15:8] == CODE_SCOMM) begin
                    n.mComm = cmd.data[7:0];
                end else if (cmd.data[15:8] == CODE_SMFR) begin
                    n.mMfr = cmd.data[7:0];
                end else begin
                    rejWr = 1'b1;
                end
            end else begin
                badCmd = 1'b1;
            end
        end

        // reads answer one cycle later
        n.rsp.valid = cmd.rd;
        n.rsp.data = '0;
        if (cmd.rd) begin
            if (cmd.code == CODE_TON) begin
                n.rsp.data = {8'h00, s.tonAct};
            end else if (cmd.code == CODE_OC) begin
                n.rsp.data = {8'h00, s.ocAct};
            end else if (cmd.code == CODE_OT) begin
                n.rsp.data = {8'h00, s.otAct};
            end else if (cmd.code == CODE_FLI) begin
                n.rsp.data = {8'h00, s.fliAct};
            end else if (cmd.code == CODE_PROP) begin
                n.rsp.data = s.propSel;
            end else if (cmd.code == CODE_CHCFG) begin
                n.rsp.data = {8'h00, s.chanCfg};
            end else if (cmd.code == CODE_RETRY) begin
                n.rsp.data = s.retryIvl;
            end else if (cmd.code == CODE_SBYTE) begin
                n.rsp.data = {8'h00, statByte};
            end else if (cmd.code == CODE_SWORD) begin
                n.rsp.data = statWord;
            end else if (cmd.code == CODE_SVOUT) begin
                n.rsp.data = {8'h00, s.sVout};
            end else if (cmd.code == CODE_SIOUT) begin
                n.rsp.data = {8'h00, s.sIout};
            end else if (cmd.code == CODE_STEMP) begin
                n.rsp.data = {8'h00, s.sTemp};
            end else if (cmd.code == CODE_SCOMM) begin
                n.rsp.data = {8'h00, s.sComm};
            end else if (cmd.code == CODE_SMFR) begin
                n.rsp.data = {8'h00, s.sMfr};
            end else begin
                badCmd = 1'b1;
            end
        end

        // sets come after clears so a same-cycle event is never lost
        if (rejWr) begin
            n.sComm[SC_DATA] = 1'b1;
        end
        if (badCmd) begin
            n.sComm[SC_CMD] = 1'b1;
        end
        if (tonDet) begin
            n.sVout[SV_TON] = 1'b1;
        end
        if (ocDet) begin
            n.sIout[SI_OC] = 1'b1;
        end
        if (otDet) begin
            n.sTemp[ST_OT] = 1'b1;
        end
        if (extLow) begin
            n.extSeen = 1'b1;
            if (!s.chanCfg[CFG_NOMFR]) begin
                n.sMfr[SM_EXT] = 1'b1;
            end
        end

        // only the detail registers feed alert, so summaries inherit their masks
        n.alert = |(s.sVout & ~s.mVout) || |(s.sIout & ~s.mIout)
            || |(s.sTemp & ~s.mTemp) || |(s.sComm & ~s.mComm)
            || |(s.sMfr & ~s.mMfr & {7'h00, !s.chanCfg[CFG_NODISCH]});
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s <= STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign rsp = s.rsp;
    assign faultLineOut = 1'b0;
    assign faultLineOe_n = !s.faultDrive;
    assign alertOut = 1'b0;
    assign alertOe_n = !s.alert;
    assign outputEnable = s.outEn;
    assign currentLimitActive = s.limit;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_oc_reject_keep: assert property (cmd.wr && cmd.code == CODE_OC
        && cmd.data[RESP_HI:RESP_LO] == RESP_BAD |=> $stable(s.ocAct))
        else $error("refused overcurrent write changed config");
    a_reject_flags_comm: assert property (cmd.wr && cmd.code == CODE_OT
        && !cmd.data[RESP_HI] |=> s.sComm[SC_DATA])
        else $error("refused overtemp write not flagged");
    a_ton_delay_zero: assert property (cmd.wr && cmd.code == CODE_TON
        && cmd.data[DELAY_HI:DELAY_LO] != DELAY_ZERO |=> $stable(s.tonAct) && s.sComm[SC_DATA])
        else $error("nonzero start-up delay accepted");
    a_nota_summary: assert property (statByte[SB_NOTA] == (|statWord[15:12]))
        else $error("none-of-the-above out of step");
    a_comm_alerts: assert property (s.sComm[SC_DATA] && !s.mComm[SC_DATA]
        ##1 s.sComm[SC_DATA] |-> !alertOe_n)
        else $error("unmasked status bit left alert released");
    a_ot_hold_off: assert property (otHold && s.st == ST_RUN |=> !outputEnable)
        else $error("output on during overtemp hold");
    a_fault_line_holds: assert property (s.faultDrive && chanOn
        && s.st != ST_RETRY |=> s.faultDrive)
        else $error("fault line released early");
    a_prop_needs_select: assert property ($rose(s.faultDrive) |-> $past(s.propSel) != '0)
        else $error("fault line driven with empty select");
    a_ext_stop_off: assert property (extStop |=> !outputEnable)
        else $error("output on after external fault stop");
    a_clear_all: assert property (cmd.wr && cmd.code == CODE_CLEAR && !condNow
        && !extLow && !rejWr |=> s.sVout == '0 && s.sIout == '0 && s.sTemp == '0)
        else $error("clear all left status bits");
    a_bit_clear_one: assert property (cmd.wr && cmd.code == CODE_STEMP
        && cmd.data[7:0] == 8'h80 && !otDet |=> s.sTemp[ST_OT] == 1'b0 && $stable(s.sVout))
        else $error("status bit clear misbehaved");

    c_retry_restart: cover property (s.st == ST_RETRY ##1 s.st == ST_RUN);
    c_latched_off: cover property (s.st == ST_RUN ##1 s.st == ST_LATCHED);
    c_ext_stop: cover property (extStop && s.st == ST_RUN);
    c_disch_hold: cover property ($fell(s.dischHold) && chanOn);
endmodule // frm_fault_alert

// File: dv/frm_host_model.sv
// Purpose: bus host that writes and reads the fault manager's commands
// Assumes: one request per call, driven on the falling edge
// Notes: released request lines show inverted values, never the last ones
`timescale 1ns/10ps
module frm_host_model (
    input wire logic clk_sys,
    output frm_pkg::frm_cmd_t cmd,
    input frm_pkg::frm_rsp_t rsp
);
    import frm_pkg::*;
    initial cmd = '0;
    // writing a 1 clears only that status bit
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk_sys);
        cmd = '{wr: 1'b1, rd: 1'b0, code: c, data: d};
        @(negedge clk_sys);
        cmd = '{wr: 1'b0, rd: 1'b0, code: ~c, data: ~d};
    endtask
    // answer stands one cycle, so it is taken at the next falling edge
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge clk_sys);
        cmd = '{wr: 1'b0, rd: 1'b1, code: c, data: 16'h0000};
        @(negedge clk_sys);
        cmd = '{wr: 1'b0, rd: 1'b0, code: ~c, data: 16'hffff};
        d = (rsp.valid === 1'b1) ? rsp.data : 16'hxxxx;
    endtask
endmodule // frm_host_model

// File: dv/frm_fault_alert_tb_top.sv
// Purpose: self-checking bench for the fault-response and alert manager
// Assumes: pins driven on the falling edge
// Notes: one task per feature; mismatches are counted, never fatal
`timescale 1ns/10ps
module frm_fault_alert_tb_top;
    import frm_pkg::*;
    logic clk_sys, reset, chanOn, ocDet, otDet, extPull_n, fOe_n, aOe_n, outEn, lim, fLine;
    logic tonDet, above;
    frm_cmd_t cmd;
    frm_rsp_t rsp;
    logic [15:0] v;
    int fail_count = 0;
    int checks_done = 0;
    // wired-and of the shared fault line
    assign fLine = fOe_n & extPull_n;
    frm_fault_alert frm_fault_alert_i (.clk_sys(clk_sys), .reset(reset), .cmd(cmd),
        .rsp(rsp), .chanOnPin(chanOn), .tonMaxDet(tonDet), .overcurrentDet(ocDet),
        .overtempDet(otDet), .aboveDecayThr(above), .faultLineIn(fLine), .faultLineOut(),
        .faultLineOe_n(fOe_n), .alertOut(), .alertOe_n(aOe_n), .outputEnable(outEn),
        .currentLimitActive(lim));
    frm_host_model frm_host_model_i (.clk_sys(clk_sys), .cmd(cmd), .rsp(rsp));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic rc(input logic [7:0] c, input logic [15:0] e, input string n);
        frm_host_model_i.rd(c, v);
        chk(n, e, v);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_regs;
        rc(CODE_OC, 16'h0000, "oc rst");
        rc(CODE_OT, 16'h00c0, "ot rst");
        rc(CODE_FLI, 16'h00c0, "fli rst");
        frm_host_model_i.wr(CODE_PROP, 16'hffff);
        rc(CODE_PROP, 16'he0d7, "prop");
    endtask
    task automatic t_refuse;
        frm_host_model_i.wr(CODE_TON, 16'h0040);
        rc(CODE_TON, 16'h0000, "ton 01");
        frm_host_model_i.wr(CODE_TON, 16'h0001);
        rc(CODE_TON, 16'h0000, "ton delay");
        frm_host_model_i.wr(CODE_OC, 16'h0040);
        rc(CODE_OC, 16'h0000, "oc 01");
        frm_host_model_i.wr(CODE_FLI, 16'h0055);
        rc(CODE_FLI, 16'h00c0, "fli bad");
        frm_host_model_i.wr(8'h00, 16'h0000);
        rc(CODE_SCOMM, 16'h00c0, "comms");
        chk("alert comms", 16'h0000, aOe_n);
        frm_host_model_i.wr(CODE_SCOMM, 16'h0040);
        rc(CODE_SCOMM, 16'h0080, "clr one");
        frm_host_model_i.wr(CODE_SCOMM, 16'h0080);
        cyc(3);
        chk("alert clr", 16'h0001, aOe_n);
    endtask
    // trip overcurrent with action a, check output after d cycles
    task automatic ocTrip(input logic [7:0] a, input int d, input logic e);
        chanOn = 1'b1;
        cyc(8);
        frm_host_model_i.wr(CODE_OC, {8'h00, a});
        ocDet = 1'b1;
        cyc(d);
        chk("oc outEn", {15'h0000, e}, outEn);
    endtask
    task automatic t_oc;
        ocTrip(8'hc0, 6, 1'b0);
        chk("oc line", 16'h0000, fOe_n);
        chk("oc alert", 16'h0001, aOe_n);
        rc(CODE_SIOUT, 16'h0080, "iout");
        ocDet = 1'b0;
        cyc(20);
        chk("latched", 16'h0000, fOe_n);
        chanOn = 1'b0;
        cyc(6);
        chk("line off", 16'h0001, fOe_n);
        ocTrip(8'h82, 90, 1'b1);
        cyc(125);
        chk("oc late", 16'h0000, outEn);
        chanOn = 1'b0;
        ocDet = 1'b0;
        cyc(6);
        ocTrip(8'h00, 6, 1'b1);
        chk("limit", 16'h0001, lim);
        chanOn = 1'b0;
        ocDet = 1'b0;
        cyc(6);
        ocTrip(8'hf8, 6, 1'b0);
        ocDet = 1'b0;
        cyc(1200);
        chk("retry on", 16'h0001, outEn);
        chk("retry line", 16'h0001, fOe_n);
        chanOn = 1'b0;
        frm_host_model_i.wr(CODE_CLEAR, 16'h0000);
    endtask
    task automatic t_ot;
        chanOn = 1'b1;
        otDet = 1'b1;
        cyc(10);
        chk("ot hold", 16'h0000, outEn);
        chk("ot alert", 16'h0000, aOe_n);
        frm_host_model_i.wr(CODE_CLEAR, 16'h0000);
        cyc(6);
        rc(CODE_STEMP, 16'h0080, "temp");
        rc(CODE_SWORD, 16'h1045, "word");
        otDet = 1'b0;
        cyc(6);
        chk("ot resume", 16'h0001, outEn);
        frm_host_model_i.wr(CODE_CLEAR, 16'h0000);
        cyc(3);
        chk("clr alert", 16'h0001, aOe_n);
        chanOn = 1'b0;
        cyc(6);
        otDet = 1'b1;
        cyc(6);
        chk("ot off line", 16'h0001, fOe_n);
        chk("ot off alert", 16'h0000, aOe_n);
        otDet = 1'b0;
        // let the detector drain through the synchroniser so clear-all sticks
        cyc(2);
        frm_host_model_i.wr(CODE_CLEAR, 16'h0000);
    endtask
    task automatic t_ext;
        chanOn = 1'b1;
        cyc(8);
        extPull_n = 1'b0;
        cyc(6);
        chk("ext stop", 16'h0000, outEn);
        chk("ext alert", 16'h0001, aOe_n);
        rc(CODE_SMFR, 16'h0001, "mfr");
        extPull_n = 1'b1;
        frm_host_model_i.wr(CODE_FLI, 16'h0000);
        extPull_n = 1'b0;
        cyc(6);
        chk("ext cont", 16'h0001, outEn);
        extPull_n = 1'b1;
        frm_host_model_i.wr(CODE_MASK, {CODE_SMFR, 8'h00});
        cyc(2);
        chk("ext unmask", 16'h0000, aOe_n);
    endtask
    task automatic t_ton;
        chanOn = 1'b0;
        frm_host_model_i.wr(CODE_TON, 16'h0080);
        rc(CODE_TON, 16'h0080, "ton 10");
        chanOn = 1'b1;
        cyc(8);
        tonDet = 1'b1;
        cyc(6);
        chk("ton off", 16'h0000, outEn);
        chk("ton line", 16'h0000, fOe_n);
        rc(CODE_SVOUT, 16'h0004, "vout");
        {tonDet, chanOn} = 2'h0;
        cyc(6);
        {above, chanOn} = 2'h3;
        cyc(8);
        chk("disch hold", 16'h0000, outEn);
        chk("disch line", 16'h0000, fOe_n);
        above = 1'b0;
        cyc(6);
        chk("disch end", 16'h0001, outEn);
        chk("disch keep", 16'h0000, fOe_n);
    endtask
    initial begin
        #(100 * 20000);
        fail_count++;
        final_report();
    end
    initial begin
        {chanOn, ocDet, otDet, tonDet, above} = 5'h00;
        extPull_n = 1'b1;
        reset = 1'b1;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        t_regs();
        t_refuse();
        t_oc();
        t_ot();
        t_ext();
        t_ton();
        final_report();
    end
endmodule // frm_fault_alert_tb_top
